// ==== kms_keypad_scanner.sv ====
// Purpose: keypad matrix scanner with register file and hardware sequencer
// Assumes: row inputs synchronous to clk_sys_i, rows idle high, key pulls row low
// Notes:   key index is column*8+row; register reads answer one cycle later
`timescale 1ns/1ps
module kms_keypad_scanner (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire kms_pkg::kms_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire logic [7:0]            row_i,
  output logic [7:0]                 col_o,
  output logic                       clk_req_o,
  output kms_pkg::kms_evt_t          evt_o
);
  import kms_pkg::*;

  // register storage
  logic [7:0]  ctrl_q, deb_q, lk_low_q, lk_high_q, to_low_q, to_high_q;
  logic [7:0]  col_reg_q, row_sense_q, sms_rw_q;
  logic [7:0]  irq_sts_q, irq_msk_q, irq_edg_q, irq_hctl_q;
  logic [63:0] key_map_q;                 // latched debounced map
  logic [63:0] scan_map_q, cand_q;        // current pass and candidate map
  logic [7:0]  rdata_q, col_q;
  logic        clk_req_q;
  kms_evt_t    evt_q, evt_d;
  kms_state_t  state_q, state_d;
  logic [2:0]  col_idx_q;
  logic [7:0]  pre_cnt_q;
  logic [5:0]  deb_cnt_q;
  logic [11:0] long_cnt_q;
  logic [15:0] to_cnt_q;

  // state to software code, used by the status register and a check
  function automatic logic [3:0] kms_state_code(input kms_state_t s);
    unique case (s)
      KMS_ST_IDLE:      return KMS_SC_IDLE;
      KMS_ST_SCAN:      return KMS_SC_SCAN;
      KMS_ST_LOAD_DEB:  return KMS_SC_LOAD_DEB;
      KMS_ST_TEST_DEB:  return KMS_SC_TEST_DEB;
      KMS_ST_GEN_EVT:   return KMS_SC_GEN_EVT;
      KMS_ST_LOAD_LONG: return KMS_SC_LOAD_LONG;
      KMS_ST_TEST_LONG: return KMS_SC_TEST_LONG;
      KMS_ST_GEN_LONG:  return KMS_SC_GEN_LONG;
      KMS_ST_TEST_TO:   return KMS_SC_TEST_TO;
      KMS_ST_GEN_TO:    return KMS_SC_GEN_TO;
      KMS_ST_LOAD_TO:   return KMS_SC_LOAD_TO;
      default:          return KMS_SC_OTHER;
    endcase
  endfunction : kms_state_code

  // control decode
  wire        power_on    = ctrl_q[KMS_BIT_POWER_ON];
  wire        repeat_en   = ctrl_q[KMS_BIT_REPEAT_EN];
  wire        held_to_en  = ctrl_q[KMS_BIT_HELD_TO_EN];
  wire        empty_to_en = ctrl_q[KMS_BIT_EMPTY_TO];
  wire        long_en     = ctrl_q[KMS_BIT_LONG_EN];
  wire        hw_mode     = ctrl_q[KMS_BIT_DEC_SEL];
  // keypad logic is cleared by soft reset or when unpowered
  wire        blk_clr     = !ctrl_q[KMS_BIT_SOFT_RST_N] || !power_on;
  wire        hw_run      = hw_mode && !blk_clr;
  wire [11:0] long_preset = {lk_high_q[3:0], lk_low_q};
  wire [2:0]  timer_prescale         = lk_high_q[7:5];
  wire [15:0] to_preset   = {to_high_q, to_low_q};
  wire        key_held    = |key_map_q;
  wire [3:0]  state_code  = kms_state_code(state_q);

  // register port decode
  wire        wr_ctrl   = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_CTRL);
  wire        wr_deb    = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_DEB);
  wire        wr_lk_lo  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_LK_LOW);
  wire        wr_lk_hi  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_LK_HIGH);
  wire        wr_to_lo  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_TO_LOW);
  wire        wr_to_hi  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_TO_HIGH);
  wire        wr_col    = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_COL);
  wire        wr_sms    = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_SMS);
  wire        wr_i_sts  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_IRQ_STS);
  wire        wr_i_msk  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_IRQ_MSK);
  wire        wr_i_edg  = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_IRQ_EDG);
  wire        wr_i_hctl = reg_req_i.wr && (reg_req_i.addr == KMS_OFS_IRQ_HCTL);
  wire        map_sel   = (reg_req_i.addr >= KMS_OFS_MAP0) && (reg_req_i.addr <= KMS_OFS_MAP7);
  wire [2:0]  map_idx   = 3'(reg_req_i.addr - KMS_OFS_MAP0);
  logic [7:0] rd_mux;

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_req_i.addr)
      KMS_OFS_CTRL:     rd_mux = ctrl_q;
      KMS_OFS_DEB:      rd_mux = deb_q;
      KMS_OFS_LK_LOW:   rd_mux = lk_low_q;
      KMS_OFS_LK_HIGH:  rd_mux = lk_high_q;
      KMS_OFS_TO_LOW:   rd_mux = to_low_q;
      KMS_OFS_TO_HIGH:  rd_mux = to_high_q;
      KMS_OFS_COL:      rd_mux = col_reg_q;
      KMS_OFS_ROW:      rd_mux = row_sense_q;
      KMS_OFS_SMS:      rd_mux = sms_rw_q | {4'h0, state_code};
      KMS_OFS_IRQ_STS:  rd_mux = irq_sts_q;
      KMS_OFS_IRQ_MSK:  rd_mux = irq_msk_q;
      KMS_OFS_IRQ_EDG:  rd_mux = irq_edg_q;
      KMS_OFS_IRQ_HCTL: rd_mux = irq_hctl_q;
      default:          rd_mux = map_sel ? key_map_q[{map_idx, 3'b000} +: 8] : 8'h00;
    endcase
  end

  // configuration registers; reserved bits masked so they read zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q     <= KMS_RST_CTRL;
      deb_q      <= 8'h00;
      lk_low_q   <= 8'h00;
      lk_high_q  <= KMS_RST_LK_HIGH;
      to_low_q   <= 8'h00;
      to_high_q  <= 8'h00;
      col_reg_q  <= KMS_RST_COL;
      sms_rw_q   <= 8'h00;
    end else begin
      if (wr_ctrl)  ctrl_q    <= reg_req_i.wdata & KMS_MASK_CTRL;
      if (wr_deb)   deb_q     <= reg_req_i.wdata & KMS_MASK_DEB;
      if (wr_lk_lo) lk_low_q  <= reg_req_i.wdata;
      if (wr_lk_hi) lk_high_q <= reg_req_i.wdata & KMS_MASK_LK_HIGH;
      if (wr_to_lo) to_low_q  <= reg_req_i.wdata;
      if (wr_to_hi) to_high_q <= reg_req_i.wdata;
      if (wr_col)   col_reg_q <= reg_req_i.wdata;
      if (wr_sms)   sms_rw_q  <= reg_req_i.wdata & KMS_MASK_SMS_RW;
    end
  end

  // interrupt handler registers are plain storage in this block
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_sts_q  <= 8'h00;
      irq_msk_q  <= KMS_RST_IRQ_MSK;
      irq_edg_q  <= KMS_RST_IRQ_EDG;
      irq_hctl_q <= KMS_RST_IRQ_HCTL;
    end else begin
      if (wr_i_sts)  irq_sts_q  <= reg_req_i.wdata;
      if (wr_i_msk)  irq_msk_q  <= reg_req_i.wdata;
      if (wr_i_edg)  irq_edg_q  <= reg_req_i.wdata;
      if (wr_i_hctl) irq_hctl_q <= reg_req_i.wdata;
    end
  end

  // read data, row sampling, pins and clock request all from flops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q     <= 8'h00;
      row_sense_q <= KMS_RST_ROW;
      col_q       <= KMS_RST_COL;
      clk_req_q   <= 1'b0;
    end else begin
      if (reg_req_i.rd) rdata_q <= rd_mux;
      row_sense_q <= row_i;
      clk_req_q   <= power_on;
      // unpowered columns float high so no key can load the rows
      if (blk_clr)      col_q <= KMS_RST_COL;
      else if (hw_mode) col_q <= ~(8'h01 << col_idx_q);
      else              col_q <= col_reg_q;
    end
  end

  // prescaler: one tick every 2^(ptv+1) clocks
  wire [7:0] pre_last = 8'((9'h002 << timer_prescale) - 9'h001);
  wire       tick     = hw_run && (pre_cnt_q == pre_last);
  wire       pass_end = tick && (col_idx_q == 3'h7);
  wire [63:0] pass_map = {~row_i, scan_map_q[55:0]};  // last column joins at pass end

  // column scan; rows sampled just before the column moves on
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || blk_clr || !hw_mode) begin
      pre_cnt_q  <= 8'h00;
      col_idx_q  <= 3'h0;
      scan_map_q <= 64'h0;
    end else begin
      pre_cnt_q <= tick ? 8'h00 : 8'(pre_cnt_q + 8'h01);
      if (tick) begin
        scan_map_q[{col_idx_q, 3'b000} +: 8] <= ~row_i;
        col_idx_q <= 3'(col_idx_q + 3'h1);
      end
    end
  end

  // a completed pass that differs from the latched map restarts debounce
  // comparing whole passes ignores bounce inside a pass; debounce then waits it out
  // trade-off: a change is seen up to one pass late, in return for a cheap comparator
  wire map_moved = pass_end && (pass_map != key_map_q);
  wire cand_moved = pass_end && (pass_map != cand_q);
  wire to_armed   = key_held ? held_to_en : empty_to_en;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    evt_d   = '0;
    unique case (state_q)
      KMS_ST_IDLE:      if (hw_run) state_d = KMS_ST_SCAN;
      KMS_ST_SCAN:      if (map_moved) state_d = KMS_ST_LOAD_DEB;
      KMS_ST_LOAD_DEB:  state_d = KMS_ST_TEST_DEB;
      KMS_ST_TEST_DEB: begin
        if (cand_moved)             state_d = KMS_ST_LOAD_DEB;
        else if (deb_cnt_q == 6'h0) state_d = KMS_ST_GEN_EVT;
      end
      KMS_ST_GEN_EVT: begin
        evt_d.key_change = 1'b1;
        state_d = (|cand_q) ? KMS_ST_LOAD_LONG : KMS_ST_LOAD_TO;
      end
      KMS_ST_LOAD_LONG: state_d = KMS_ST_TEST_LONG;
      KMS_ST_TEST_LONG: begin
        if (map_moved) state_d = KMS_ST_LOAD_DEB;
        else if (long_cnt_q == 12'h0 && (long_en || repeat_en)) state_d = KMS_ST_GEN_LONG;
        else if (to_cnt_q == 16'h0 && held_to_en) state_d = KMS_ST_GEN_TO;
        else if (!long_en && !repeat_en) state_d = KMS_ST_TEST_TO;
      end
      KMS_ST_GEN_LONG: begin
        evt_d.long_key   = long_en;
        evt_d.repeat_key = repeat_en;
        state_d = repeat_en ? KMS_ST_LOAD_LONG : KMS_ST_TEST_TO;
      end
      KMS_ST_LOAD_TO:   state_d = empty_to_en ? KMS_ST_TEST_TO : KMS_ST_SCAN;
      KMS_ST_TEST_TO: begin
        if (map_moved) state_d = KMS_ST_LOAD_DEB;
        else if (to_cnt_q == 16'h0 && to_armed) state_d = KMS_ST_GEN_TO;
      end
      KMS_ST_GEN_TO: begin
        evt_d.timeout = 1'b1;
        state_d = KMS_ST_SCAN;
      end
      default:          state_d = KMS_ST_IDLE;   // unused codes recover to idle
    endcase
  end

  // sequencer state, timers and latched maps
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || blk_clr) begin
      state_q    <= KMS_ST_IDLE;
      evt_q      <= '0;
      deb_cnt_q  <= 6'h0;
      long_cnt_q <= 12'h0;
      to_cnt_q   <= 16'h0;
      cand_q     <= 64'h0;
      key_map_q  <= 64'h0;
    end else begin
      state_q <= hw_mode ? state_d : KMS_ST_IDLE;
      evt_q   <= hw_mode ? evt_d : '0;
      if (map_moved || cand_moved) cand_q <= pass_map;
      if (state_q == KMS_ST_LOAD_DEB) deb_cnt_q <= deb_q[5:0];
      else if (tick && deb_cnt_q != 6'h0) deb_cnt_q <= 6'(deb_cnt_q - 6'h1);
      if (state_q == KMS_ST_GEN_EVT) begin
        key_map_q <= cand_q;
        to_cnt_q  <= to_preset;
      end else if (tick && to_cnt_q != 16'h0) begin
        to_cnt_q <= 16'(to_cnt_q - 16'h1);
      end
      if (state_q == KMS_ST_LOAD_LONG) long_cnt_q <= long_preset;
      else if (tick && long_cnt_q != 12'h0) long_cnt_q <= 12'(long_cnt_q - 12'h1);
    end
  end

  assign reg_rdata_o = rdata_q;
  assign col_o       = col_q;
  assign clk_req_o   = clk_req_q;
  assign evt_o       = evt_q;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_clock_request: assert property (##1 clk_req_o == $past(power_on))
    else $error("clock request does not follow power-on bit");
  chk_repeat_gated: assert property (evt_o.repeat_key |-> $past(repeat_en))
    else $error("repeat event while repeat detection disabled");
  chk_long_gated: assert property (evt_o.long_key |-> $past(long_en))
    else $error("long-key event while long-key detection disabled");
  chk_timeout_gated: assert property (evt_o.timeout |-> $past(to_armed, 2))
    else $error("timeout event while timeout detection disabled");
  chk_soft_reset_hold: assert property (blk_clr |=> state_q == KMS_ST_IDLE && evt_o == '0)
    else $error("keypad logic active while held in reset");
  chk_sw_col_drive: assert property (!hw_mode && !blk_clr |=> col_o == $past(col_reg_q))
    else $error("column pins do not follow column register");
  chk_row_live: assert property (##1 row_sense_q == $past(row_i))
    else $error("row register does not follow row pins");
  chk_one_col_low: assert property (hw_run [*2] |-> $onehot(~col_o))
    else $error("hardware scan does not drive exactly one column low");
  chk_deb_reads_zero: assert property (reg_req_i.rd && reg_req_i.addr == KMS_OFS_DEB |=>
                                       reg_rdata_o[7:6] == 2'b00)
    else $error("debounce reserved bits read nonzero");
  chk_state_code: assert property (reg_req_i.rd && reg_req_i.addr == KMS_OFS_SMS |=>
                                   reg_rdata_o[3:0] == $past(state_code))
    else $error("status field does not show sequencer state");
  chk_lk_reserved: assert property (reg_req_i.rd && reg_req_i.addr == KMS_OFS_LK_HIGH |=>
                                    !reg_rdata_o[4])
    else $error("prescaler register reserved bit reads nonzero");
  chk_ctrl_reserved: assert property (reg_req_i.rd && reg_req_i.addr == KMS_OFS_CTRL |=>
                                      !reg_rdata_o[7])
    else $error("control register reserved bit reads nonzero");

  // unpowered keypad parks pins high with no clock; no events in software mode; one-cycle events; ticks never adjacent
  chk_unpowered_idle: assert property (!power_on |=> col_o == 8'hff && !clk_req_o)
    else $error("unpowered keypad drives columns or requests its clock");
  chk_sw_no_events: assert property (!hw_mode |=> evt_o == '0)
    else $error("event raised in software scanning mode");
  chk_event_pulse: assert property (evt_o != '0 |=> evt_o == '0)
    else $error("event output held for more than one cycle");
  chk_tick_spacing: assert property (tick |=> !tick)
    else $error("prescaler ticks on two cycles in a row");

  // timer loads and key map latch; a soft reset landing on the same edge wins, so it is left out
  chk_deb_reload: assert property (!blk_clr && state_q == KMS_ST_LOAD_DEB |=>
                                   {2'b00, deb_cnt_q} == $past(deb_q))
    else $error("debounce counter not loaded from its preset");
  chk_long_reload: assert property (!blk_clr && state_q == KMS_ST_LOAD_LONG |=>
                                    long_cnt_q == $past(long_preset))
    else $error("long-key counter not loaded from its preset");
  chk_to_reload: assert property (!blk_clr && state_q == KMS_ST_GEN_EVT |=>
                                  to_cnt_q == $past(to_preset))
    else $error("timeout counter not loaded from its preset");
  chk_map_latch: assert property (!blk_clr && state_q == KMS_ST_GEN_EVT |=>
                                  key_map_q == $past(cand_q))
    else $error("key map not latched from the debounced candidate");

  // main scenarios
  cov_key_event:   cover property (evt_o.key_change);
  cov_long_event:  cover property (evt_o.long_key);
  cov_repeat_twice: cover property (evt_o.repeat_key ##[1:1000] evt_o.repeat_key);
  cov_timeout:     cover property (evt_o.timeout);
  cov_held_timeout: cover property (evt_o.timeout && key_held);

endmodule : kms_keypad_scanner

// ==== kms_pkg.sv ====
// Purpose: shared constants and types of the keypad matrix scanner
// Assumes: byte-wide register port, one system clock
// Notes:   offsets are register indexes on the auxiliary register port
package kms_pkg;

  // register offsets
  localparam logic [4:0] KMS_OFS_CTRL     = 5'h00;
  localparam logic [4:0] KMS_OFS_DEB      = 5'h01;
  localparam logic [4:0] KMS_OFS_LK_LOW   = 5'h02;
  localparam logic [4:0] KMS_OFS_LK_HIGH  = 5'h03;
  localparam logic [4:0] KMS_OFS_TO_LOW   = 5'h04;
  localparam logic [4:0] KMS_OFS_TO_HIGH  = 5'h05;
  localparam logic [4:0] KMS_OFS_COL      = 5'h06;
  localparam logic [4:0] KMS_OFS_ROW      = 5'h07;
  localparam logic [4:0] KMS_OFS_SMS      = 5'h08;
  localparam logic [4:0] KMS_OFS_MAP0     = 5'h09;
  localparam logic [4:0] KMS_OFS_MAP7     = 5'h10;
  localparam logic [4:0] KMS_OFS_IRQ_STS  = 5'h11;
  localparam logic [4:0] KMS_OFS_IRQ_MSK  = 5'h12;
  localparam logic [4:0] KMS_OFS_IRQ_EDG  = 5'h16;
  localparam logic [4:0] KMS_OFS_IRQ_HCTL = 5'h17;

  // control register fields
  localparam int KMS_BIT_POWER_ON   = 6;
  localparam int KMS_BIT_REPEAT_EN  = 5;
  localparam int KMS_BIT_HELD_TO_EN = 4;
  localparam int KMS_BIT_EMPTY_TO   = 3;
  localparam int KMS_BIT_LONG_EN    = 2;
  localparam int KMS_BIT_DEC_SEL    = 1;
  localparam int KMS_BIT_SOFT_RST_N = 0;

  // writable masks (reserved bits read zero)
  localparam logic [7:0] KMS_MASK_CTRL    = 8'h7f;
  localparam logic [7:0] KMS_MASK_DEB     = 8'h3f;
  localparam logic [7:0] KMS_MASK_LK_HIGH = 8'hef;
  localparam logic [7:0] KMS_MASK_SMS_RW  = 8'h30;

  // reset values
  localparam logic [7:0] KMS_RST_CTRL     = 8'h03;
  localparam logic [7:0] KMS_RST_LK_HIGH  = 8'he0;
  localparam logic [7:0] KMS_RST_COL      = 8'hff;
  localparam logic [7:0] KMS_RST_ROW      = 8'hff;
  localparam logic [7:0] KMS_RST_IRQ_MSK  = 8'h0f;
  localparam logic [7:0] KMS_RST_IRQ_EDG  = 8'h55;
  localparam logic [7:0] KMS_RST_IRQ_HCTL = 8'h01;

  // sequencer state codes seen by software
  localparam logic [3:0] KMS_SC_IDLE      = 4'h0;
  localparam logic [3:0] KMS_SC_SCAN      = 4'h1;
  localparam logic [3:0] KMS_SC_LOAD_DEB  = 4'h2;
  localparam logic [3:0] KMS_SC_TEST_DEB  = 4'h3;
  localparam logic [3:0] KMS_SC_GEN_EVT   = 4'h4;
  localparam logic [3:0] KMS_SC_LOAD_LONG = 4'h6;
  localparam logic [3:0] KMS_SC_TEST_LONG = 4'h7;
  localparam logic [3:0] KMS_SC_GEN_LONG  = 4'h8;
  localparam logic [3:0] KMS_SC_TEST_TO   = 4'ha;
  localparam logic [3:0] KMS_SC_GEN_TO    = 4'hb;
  localparam logic [3:0] KMS_SC_LOAD_TO   = 4'hd;
  localparam logic [3:0] KMS_SC_OTHER     = 4'hf;

  // prescaler reset value and tick period base: tick every 2^(ptv+1) clocks
  localparam logic [2:0] KMS_RST_PTV      = 3'h7;

  typedef enum logic [3:0] {
    KMS_ST_IDLE, KMS_ST_SCAN, KMS_ST_LOAD_DEB, KMS_ST_TEST_DEB, KMS_ST_GEN_EVT,
    KMS_ST_LOAD_LONG, KMS_ST_TEST_LONG, KMS_ST_GEN_LONG, KMS_ST_TEST_TO,
    KMS_ST_GEN_TO, KMS_ST_LOAD_TO
  } kms_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } kms_reg_req_t;

  typedef struct packed {
    logic key_change;
    logic long_key;
    logic repeat_key;
    logic timeout;
  } kms_evt_t;

endpackage : kms_pkg

// ==== kms_keypad_model.sv ====
// Purpose: behavioural keypad matrix on the far side of the scanner pins
// Assumes: rows pulled up; a pressed key shorts its column to its row
// Notes:   key index is column*8+row, as the scanner decodes it
`timescale 1ns/1ps
module kms_keypad_model (
  input  wire logic [7:0]  col_i,
  input  wire logic [63:0] pressed_i,
  output logic [7:0]       row_o
);
  // open rows rest at the pull-up level; any low column through a pressed key wins
  always_comb begin
    row_o = 8'hff;
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 8; r++) begin
        if (!col_i[c] && pressed_i[c*8+r]) row_o[r] = 1'b0;
      end
    end
  end
endmodule : kms_keypad_model

// ==== keypad_matrix_scanner_tb.sv ====
// Purpose: self-checking bench for the keypad matrix scanner
// Assumes: strobe register port, prescaler 0 for short timer runs
// Notes:   random keys and register data come from a fixed seed
`timescale 1ns/1ps
module keypad_matrix_scanner_tb;
  import kms_pkg::*;
  logic         clk_sys_i;
  logic         rst_n_i;
  kms_reg_req_t req;
  logic [7:0]   rdata;
  logic [7:0]   row;
  logic [7:0]   col;
  logic         clk_req;
  kms_evt_t     evt;
  logic [63:0]  pressed;
  logic [7:0]   v;
  logic [7:0]   m;
  logic [7:0]   modes [5] = '{8'h43, 8'h47, 8'h67, 8'h4b, 8'h57};
  int           fail_count, n_tests, cycles, k;
  int           n_chg, n_long, n_rep, n_to;

  kms_keypad_scanner dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .row_i(row), .col_o(col), .clk_req_o(clk_req), .evt_o(evt));
  kms_keypad_model keys (.col_i(col), .pressed_i(pressed), .row_o(row));

  always #2 clk_sys_i = ~clk_sys_i;

  // event counters and hang guard; generous ceiling, the run needs about 5k cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (evt.key_change === 1'b1) n_chg++;
    if (evt.long_key === 1'b1) n_long++;
    if (evt.repeat_key === 1'b1) n_rep++;
    if (evt.timeout === 1'b1) n_to++;
    if (cycles == 50000) begin
      fail_count++;
      close_out();
    end
  end

  function automatic logic [7:0] rst_val(input logic [4:0] a);
    case (a)
      5'h00:   return 8'h03;
      5'h03:   return 8'he0;
      5'h06:   return 8'hff;
      5'h07:   return 8'hff;
      5'h12:   return 8'h0f;
      5'h16:   return 8'h55;
      5'h17:   return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : rst_val

  // readback after a write: row sense stays live (all high while unpowered)
  function automatic logic [7:0] exp_wr(input logic [4:0] a, input logic [7:0] d);
    case (a)
      5'h01:   return d & 8'h3f;
      5'h02, 5'h04, 5'h05, 5'h06, 5'h11, 5'h12, 5'h16, 5'h17: return d;
      5'h03:   return d & 8'hef;
      5'h07:   return 8'hff;
      5'h08:   return d & 8'h30;
      default: return 8'h00;
    endcase
  endfunction : exp_wr

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req <= '0;
  endtask : reg_wr

  // read data is loaded at the edge that takes the strobe
  task automatic check_rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    req <= '0;
    #1 check8("register read", exp, rdata);
  endtask : check_rd

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // main sequence: reset map, register access, software scan, hardware modes
  initial begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    req = '0;
    pressed = '0;
    void'($urandom(32'h107238a3));
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 24; a++) check_rd(a[4:0], rst_val(a[4:0]));
    check8("clock request", 8'h00, {7'h0, clk_req});
    for (int a = 1; a < 24; a++) begin
      v = 8'($urandom);
      reg_wr(a[4:0], v);
      check_rd(a[4:0], exp_wr(a[4:0], v));
    end
    // software scanning: column register on the pins, rows read back live
    reg_wr(KMS_OFS_CTRL, 8'h41);
    reg_wr(KMS_OFS_SMS, 8'h30);
    k = $urandom_range(63);
    v = 8'($urandom);
    v[k/8] = 1'b0;
    pressed <= 64'h1 << k;
    reg_wr(KMS_OFS_COL, v);
    repeat (3) @(posedge clk_sys_i);
    #1 check8("clock request", 8'h01, {7'h0, clk_req});
    check8("column pins", v, col);
    check_rd(KMS_OFS_ROW, ~(8'h01 << (k % 8)));
    check_rd(KMS_OFS_SMS, {4'h3, KMS_SC_IDLE});
    check_rd(KMS_OFS_CTRL, 8'h41);
    // hardware sequencer: shortest tick, zero debounce, short long and timeout presets
    pressed <= '0;
    reg_wr(KMS_OFS_DEB, 8'h00);
    reg_wr(KMS_OFS_LK_LOW, 8'h03);
    reg_wr(KMS_OFS_LK_HIGH, 8'h00);
    reg_wr(KMS_OFS_TO_LOW, 8'h05);
    reg_wr(KMS_OFS_TO_HIGH, 8'h00);
    foreach (modes[i]) begin
      m = modes[i];
      reg_wr(KMS_OFS_CTRL, 8'h40);
      repeat (2) @(posedge clk_sys_i);
      #1 check8("column pins in reset", 8'hff, col);
      reg_wr(KMS_OFS_CTRL, m);
      n_chg = 0;
      n_long = 0;
      n_rep = 0;
      n_to = 0;
      k = $urandom_range(63);
      repeat (40) @(posedge clk_sys_i);
      pressed <= 64'h1 << k;
      for (int t = 0; t < 300 && n_chg == 0; t++) @(posedge clk_sys_i);
      #1 check8("low columns", 8'h01, 8'($countones(~col)));
      for (int b = 0; b < 8; b++) begin
        check_rd(KMS_OFS_MAP0 + 5'(b), (b == k / 8) ? 8'h01 << (k % 8) : 8'h00);
      end
      // with no detection enabled the sequencer parks in the timeout test state
      if (m == 8'h43) check_rd(KMS_OFS_SMS, {4'h3, KMS_SC_TEST_TO});
      repeat (400) @(posedge clk_sys_i);
      pressed <= '0;
      repeat (400) @(posedge clk_sys_i);
      #1 check8("change event", 8'h01, {7'h0, n_chg != 0});
      check8("long event", {7'h0, m[2]}, {7'h0, n_long != 0});
      check8("repeat event", {7'h0, m[5]}, {7'h0, n_rep != 0});
      check8("timeout event", {7'h0, m[3] | m[4]}, {7'h0, n_to != 0});
    end
    reg_wr(KMS_OFS_CTRL, 8'h03);
    repeat (3) @(posedge clk_sys_i);
    #1 check8("clock request", 8'h00, {7'h0, clk_req});
    check8("column pins off", 8'hff, col);
    close_out();
  end
endmodule : keypad_matrix_scanner_tb
